// ===== hdl/rtc_evt.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"
module rtc_evt import rtc_pkg::*; #(
   parameter int SLOTS = `RTC_EVT_SLOTS
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       cap_i,
   input  wire logic       clr_i,
   input  wire logic [1:0] idx_i,
   input  wire rtc_stamp_t now_i,
   output rtc_stamp_t      stamp_o,
   output logic [2:0]      count_o
);
   if (SLOTS != 4) begin : g_bad
      $error("rtc_evt: index serves four slots only");
   end

   rtc_stamp_t slot_r [SLOTS];
   logic [2:0] cnt_r;
   wire logic  first = (cnt_r == 3'h0) | clr_i;

   // A capture with a clear in the same cycle restarts the count at one, as the first event
   always_ff @(posedge clk_i) begin
      if (rst_i)
         cnt_r <= 3'h0;
      else if (cap_i)
         cnt_r <= clr_i ? 3'h1 : (cnt_r == 3'(SLOTS)) ? cnt_r : cnt_r + 3'h1;
      else if (clr_i)
         cnt_r <= 3'h0;
   end

   // Slot 0 keeps the first event, the rest shift newest in
   always_ff @(posedge clk_i) begin
      if (cap_i & first)
         slot_r[0] <= now_i;
      else if (cap_i) begin
         slot_r[1] <= now_i;
         for (int k = 2; k < SLOTS; k++)
            slot_r[k] <= slot_r[k-1];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         stamp_o <= '0;
      else
         stamp_o <= ({1'b0, idx_i} < cnt_r) ? slot_r[idx_i] : '0;
   end

   assign count_o = cnt_r;

   a_first_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      (cnt_r != 3'h0) && !clr_i |=> slot_r[0] == $past(slot_r[0]))
      else $error("first event stamp overwritten");
   a_count_sat: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_i && !clr_i && (cnt_r == 3'h4) |=> cnt_r == 3'h4)
      else $error("event count left four");
endmodule
`default_nettype wire

// ===== hdl/rtc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_sync import rtc_pkg::*; #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o,
   output logic      [W-1:0] rise_o
);
   if (W < 1) begin : g_bad
      $error("rtc_sync: width below one");
   end

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] last_r;

   // Only sync_r reads meta_r
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= '0;
         sync_r <= '0;
         last_r <= '0;
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign q_o    = sync_r;
   assign rise_o = sync_r & ~last_r;
endmodule
`default_nettype wire

// ===== hdl/rtc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defines.svh"
module rtc_top import rtc_pkg::*; #(
   parameter int XTAL_HZ    = `RTC_XTAL_HZ,
   parameter int MAINS_LOSS = `RTC_MAINS_LOSS
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        mains_i,
   input  wire logic        xtal_i,
   input  wire logic        on_battery_i,
   input  wire logic        bat_below85_i,
   input  wire logic        bat_below75_i,
   input  wire logic [5:0]  vdd_below_i,
   input  wire logic        event_input_i,
   output logic             irq_n_o,
   output logic             irq_oe_o,
   output logic             event_detect_out_n_o,
   output logic             event_detect_out_oe_o
);
   if (XTAL_HZ < 2 || XTAL_HZ > 65535 || MAINS_LOSS < 2 || MAINS_LOSS > 65535)
   begin : g_bad
      $error("rtc_top: count outside 16-bit range");
   end

   logic [11:0] pin_s;
   logic [11:0] pin_r;
   logic [7:0]  cal_r [`RTC_NFIELD];
   logic [7:0]  cal_nxt [`RTC_NFIELD];
   logic [7:0]  alm_r [2][`RTC_NFIELD];
   logic [7:0]  dst_r [4];
   logic [7:0]  ram_r [`RTC_RAM_WORDS];
   logic [7:0]  ctrl_r;
   logic [5:0]  stat_r;
   logic [5:0]  stat_set;
   logic [2:0]  trip_r;
   logic [1:0]  evidx_r;
   logic [1:0]  armed_r;
   logic [1:0]  fire;
   logic [15:0] div_r;
   logic [15:0] tb_top;
   logic [15:0] loss_r;
   logic        lost_r;
   logic        upd_r;
   logic        ack_r;
   logic        dst_done_r;
   logic        dst_set;
   logic [7:0]  rd;
   logic [31:0] dat_r;
   rtc_src_e    src;
   rtc_stamp_t  now;
   rtc_stamp_t  stamp;

   rtc_sync #(.W(12)) u_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .d_i    ({vdd_below_i, event_input_i, bat_below75_i, bat_below85_i,
                on_battery_i, xtal_i, mains_i}),
      .q_o    (pin_s),
      .rise_o (pin_r)
   );

   wire logic       mains_rise = pin_r[0];
   wire logic       xtal_rise  = pin_r[1];
   wire logic       on_bat     = pin_s[2];
   wire logic       b85        = pin_s[3];
   wire logic       b75        = pin_s[4];
   wire logic       ev_rise    = pin_r[5];
   wire logic [5:0] vdd_s      = pin_s[11:6];

   // Bus decode
   wire logic       req    = wb_cyc_i & wb_stb_i;
   wire logic       bus_ok = ~on_bat | ctrl_r[`RTC_C_BUSBAT];
   wire logic       wr     = req & ack_r & wb_we_i & wb_sel_i[0] & bus_ok;
   wire logic [6:0] pg     = wb_adr_i[11:5];
   wire logic [2:0] sub    = wb_adr_i[4:2];
   wire logic [7:0] wd     = wb_dat_i[7:0];
   wire logic       is_ram = wb_adr_i[11:9] == `RTC_PG_RAM;
   wire logic       is_ctl = pg == `RTC_PG_CTL;
   wire logic       wr_cal = wr & (pg == `RTC_PG_CAL) & (sub != `RTC_I_NONE);
   wire logic       wr_ctl = wr & is_ctl & (sub == `RTC_I_CTRL);
   wire logic       wr_st  = wr & is_ctl & (sub == `RTC_I_STAT);
   wire logic       wr_trp = wr & is_ctl & (sub == `RTC_I_TRIP);
   wire logic       wr_evx = wr & is_ctl & (sub == `RTC_I_EVIDX);
   wire logic       wr_dst = wr & is_ctl & sub[2];
   wire logic       wr_ram = wr & is_ram;
   wire logic       any_wr = req & ack_r & wb_we_i;
   wire logic [1:0] wr_alm;
   assign wr_alm[0] = wr & (pg == `RTC_PG_ALM0) & (sub != `RTC_I_NONE);
   assign wr_alm[1] = wr & (pg == `RTC_PG_ALM0 + 7'h01) & (sub != `RTC_I_NONE);

   // Timebase: mains edges unless mains is gone or on backup
   assign src = (on_bat | lost_r) ? RTC_SRC_XTAL : RTC_SRC_MAINS;
   wire logic tb_edge = (src == RTC_SRC_XTAL) ? xtal_rise : mains_rise;
   assign tb_top = (src == RTC_SRC_XTAL) ? 16'(XTAL_HZ - 1)
                 : ctrl_r[`RTC_C_60HZ] ? 16'(`RTC_MAINS60 - 1) : 16'(`RTC_MAINS50 - 1);
   // Compare is >= so a source switch mid-second cannot overrun
   wire logic tick = tb_edge & (div_r >= tb_top);

   always_ff @(posedge clk_i) begin
      if (rst_i)
         div_r <= 16'h0;
      else if (tb_edge)
         div_r <= tick ? 16'h0 : div_r + 16'h1;
   end

   // Mains counted lost after a run of crystal edges with no mains edge
   always_ff @(posedge clk_i) begin
      if (rst_i | mains_rise) begin
         loss_r <= 16'h0;
         lost_r <= 1'b0;
      end else if (xtal_rise & ~lost_r) begin
         loss_r <= loss_r + 16'h1;
         lost_r <= loss_r >= 16'(MAINS_LOSS - 1);
      end
   end

   function automatic logic [7:0] dim(input logic [7:0] mo, input logic [7:0] yr);
      case (mo)
         8'h02:                      dim = (yr[1:0] == 2'b00) ? 8'h1d : 8'h1c;
         8'h04, 8'h06, 8'h09, 8'h0b: dim = 8'h1e;
         default:                    dim = 8'h1f;
      endcase
   endfunction

   // Calendar cascade; years 00..99 stand for 2000..2099, every fourth leap
   always_comb begin
      for (int i = 0; i < `RTC_NFIELD; i++)
         cal_nxt[i] = cal_r[i];
      dst_set = 1'b0;
      if (tick) begin
         cal_nxt[`RTC_F_SEC] = cal_r[`RTC_F_SEC] + 8'h01;
         if (cal_r[`RTC_F_SEC] == `RTC_MAX_SEC) begin
            cal_nxt[`RTC_F_SEC] = 8'h00;
            cal_nxt[`RTC_F_MIN] = cal_r[`RTC_F_MIN] + 8'h01;
            if (cal_r[`RTC_F_MIN] == `RTC_MAX_SEC) begin
               cal_nxt[`RTC_F_MIN]  = 8'h00;
               cal_nxt[`RTC_F_HOUR] = cal_r[`RTC_F_HOUR] + 8'h01;
               if (cal_r[`RTC_F_HOUR] == `RTC_MAX_HOUR) begin
                  cal_nxt[`RTC_F_HOUR] = 8'h00;
                  cal_nxt[`RTC_F_WDAY] = (cal_r[`RTC_F_WDAY] >= `RTC_MAX_WDAY) ? 8'h00
                                       : cal_r[`RTC_F_WDAY] + 8'h01;
                  cal_nxt[`RTC_F_DATE] = cal_r[`RTC_F_DATE] + 8'h01;
                  if (cal_r[`RTC_F_DATE] >= dim(cal_r[`RTC_F_MON], cal_r[`RTC_F_YEAR]))
                  begin
                     cal_nxt[`RTC_F_DATE] = `RTC_RST_DAY;
                     cal_nxt[`RTC_F_MON]  = cal_r[`RTC_F_MON] + 8'h01;
                     if (cal_r[`RTC_F_MON] >= `RTC_MAX_MON) begin
                        cal_nxt[`RTC_F_MON]  = `RTC_RST_DAY;
                        cal_nxt[`RTC_F_YEAR] = (cal_r[`RTC_F_YEAR] >= `RTC_MAX_YEAR)
                                             ? 8'h00 : cal_r[`RTC_F_YEAR] + 8'h01;
                     end
                  end
               end
            end
         end
         // Daylight saving acts on entering 02:00:00
         if (ctrl_r[`RTC_C_DST] && cal_nxt[`RTC_F_HOUR] == `RTC_DST_HOUR
             && cal_nxt[`RTC_F_MIN] == 8'h00 && cal_nxt[`RTC_F_SEC] == 8'h00) begin
            if (cal_r[`RTC_F_MON] == dst_r[0] && cal_r[`RTC_F_DATE] == dst_r[1])
               cal_nxt[`RTC_F_HOUR] = `RTC_DST_HOUR + 8'h01;
            else if (cal_r[`RTC_F_MON] == dst_r[2] && cal_r[`RTC_F_DATE] == dst_r[3]
                     && !dst_done_r) begin
               cal_nxt[`RTC_F_HOUR] = `RTC_DST_HOUR - 8'h01;
               dst_set = 1'b1;
            end
         end
      end
   end

   // A software write to a field overrides that field's tick update
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < `RTC_NFIELD; i++) begin
         if (rst_i)
            cal_r[i] <= (i == `RTC_F_DATE || i == `RTC_F_MON) ? `RTC_RST_DAY : 8'h00;
         else if (wr_cal && sub == 3'(i))
            cal_r[i] <= wd;
         else
            cal_r[i] <= cal_nxt[i];
      end
   end

   // Fall-back happens once; the guard lifts when the date moves on
   always_ff @(posedge clk_i) begin
      if (rst_i)
         dst_done_r <= 1'b0;
      else if (dst_set)
         dst_done_r <= 1'b1;
      else if (cal_r[`RTC_F_DATE] != dst_r[3])
         dst_done_r <= 1'b0;
   end

   // Alarms: bit 7 of each field enables its compare
   for (genvar a = 0; a < 2; a++) begin : g_alm
      logic [`RTC_NFIELD-1:0] hit;
      logic [`RTC_NFIELD-1:0] en;
      always_comb begin
         for (int j = 0; j < `RTC_NFIELD; j++) begin
            en[j]  = alm_r[a][j][`RTC_A_EN];
            hit[j] = ~en[j] | (alm_r[a][j][6:0] == cal_r[j][6:0]);
         end
      end
      assign fire[a] = upd_r & armed_r[a] & (&hit) & (|en);
      always_ff @(posedge clk_i) begin
         for (int j = 0; j < `RTC_NFIELD; j++) begin
            if (rst_i)
               alm_r[a][j] <= 8'h00;
            else if (wr_alm[a] && sub == 3'(j))
               alm_r[a][j] <= wd;
         end
      end
   end

   wire logic [1:0] rpt = ctrl_r[`RTC_C_RPT +: 2];

   // Without repeat an alarm disarms after firing; a write re-arms it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upd_r   <= 1'b0;
         armed_r <= 2'b00;
      end else begin
         upd_r   <= tick;
         armed_r <= (armed_r & ~(fire & ~rpt)) | wr_alm;
      end
   end

   wire logic       ev_hit = ev_rise & ctrl_r[`RTC_C_EVEN];
   wire logic       bo_hit = (trip_r < 3'(`RTC_BO_LEVELS)) ? vdd_s[trip_r] : 1'b0;
   wire logic [5:0] st_clr = wr_st ? wd[5:0] : 6'h00;
   assign stat_set = {b75, b85, bo_hit, ev_hit, fire};

   // Sticky status, write one to clear; a new event wins over its clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r  <= 8'h00;
         stat_r  <= 6'h00;
         trip_r  <= 3'h0;
         evidx_r <= 2'h0;
      end else begin
         stat_r <= (stat_r & ~st_clr) | stat_set;
         if (wr_ctl)
            ctrl_r <= wd;
         if (wr_trp)
            trip_r <= wd[2:0];
         if (wr_evx)
            evidx_r <= wd[1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      for (int k = 0; k < 4; k++) begin
         if (rst_i)
            dst_r[k] <= 8'h00;
         else if (wr_dst && sub[1:0] == 2'(k))
            dst_r[k] <= wd;
      end
   end

   // User memory has no reset: it must survive resets and backup
   always_ff @(posedge clk_i) begin
      if (wr_ram)
         ram_r[wb_adr_i[8:2]] <= wd;
   end

   always_comb begin
      for (int i = 0; i < `RTC_NFIELD; i++)
         now[i] = cal_r[i];
   end

   rtc_evt u_evt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .cap_i   (ev_hit),
      .clr_i   (wr_evx & wd[`RTC_EV_CLR]),
      .idx_i   (evidx_r),
      .now_i   (now),
      .stamp_o (stamp),
      .count_o ()
   );

   // Read select; unmapped words read zero
   always_comb begin
      rd = 8'h00;
      if (is_ram)
         rd = ram_r[wb_adr_i[8:2]];
      else if (sub != `RTC_I_NONE) begin
         case (pg)
            `RTC_PG_CAL:          rd = cal_r[sub];
            `RTC_PG_ALM0:         rd = alm_r[0][sub];
            `RTC_PG_ALM0 + 7'h01: rd = alm_r[1][sub];
            `RTC_PG_EVT:          rd = stamp[sub];
            default:              rd = 8'h00;
         endcase
      end
      if (is_ctl) begin
         case (sub)
            `RTC_I_CTRL:  rd = ctrl_r;
            `RTC_I_STAT:  rd = {src == RTC_SRC_XTAL, on_bat, stat_r};
            `RTC_I_TRIP:  rd = {5'h00, trip_r};
            `RTC_I_EVIDX: rd = {6'h00, evidx_r};
            default:      rd = dst_r[sub[1:0]];
         endcase
      end
   end

   // One wait state; gated reads return zero and gated writes drop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0;
      end else begin
         ack_r <= req & ~ack_r;
         dat_r <= {24'h0, bus_ok ? rd : 8'h00};
      end
   end

   assign wb_ack_o              = ack_r;
   assign wb_dat_o              = dat_r;
   assign irq_n_o               = 1'b0;
   assign irq_oe_o              = |(stat_r[1:0] & ctrl_r[`RTC_C_IRQEN +: 2]);
   assign event_detect_out_n_o  = 1'b0;
   assign event_detect_out_oe_o = stat_r[`RTC_S_EVT];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_min_end;
      tick && !any_wr && cal_r[`RTC_F_SEC] == `RTC_MAX_SEC;
   endsequence
   sequence s_feb28_end;
      s_min_end ##0 cal_r[`RTC_F_MIN] == `RTC_MAX_SEC
         && cal_r[`RTC_F_HOUR] == `RTC_MAX_HOUR && cal_r[`RTC_F_MON] == 8'h02
         && cal_r[`RTC_F_DATE] == 8'h1c;
   endsequence

   a_sec_wrap: assert property (
      s_min_end |=> cal_r[`RTC_F_SEC] == 8'h00
         && cal_r[`RTC_F_MIN] != $past(cal_r[`RTC_F_MIN]))
      else $error("seconds did not wrap into minutes");
   a_leap_day: assert property (
      s_feb28_end ##0 cal_r[`RTC_F_YEAR][1:0] == 2'b00 |=> cal_r[`RTC_F_DATE] == 8'h1d)
      else $error("leap day skipped");
   a_dst_fwd: assert property (
      tick && !any_wr && ctrl_r[`RTC_C_DST] && cal_nxt[`RTC_F_MIN] == 8'h00
         && cal_nxt[`RTC_F_SEC] == 8'h00 && cal_r[`RTC_F_HOUR] == 8'h01
         && cal_r[`RTC_F_MON] == dst_r[0] && cal_r[`RTC_F_DATE] == dst_r[1]
      |=> cal_r[`RTC_F_HOUR] == 8'h03)
      else $error("spring forward missed");
   a_alarm_flag: assert property (
      fire[0] |=> stat_r[`RTC_S_ALM] ##1 stat_r[`RTC_S_ALM] || $past(wr_st))
      else $error("alarm status not set");
   a_irq_pin: assert property (
      fire[1] && ctrl_r[`RTC_C_IRQEN + 1] && !wr_ctl |=> irq_oe_o)
      else $error("interrupt pin not driven on alarm");
   a_one_shot: assert property (
      fire[0] && !rpt[0] && !wr_alm[0] |=> !armed_r[0] && !fire[0])
      else $error("one-shot alarm stayed armed");
   a_xtal_batt: assert property (
      on_bat |-> src == RTC_SRC_XTAL)
      else $error("backup mode not on crystal");
   a_bat_warn: assert property (
      b75 |=> stat_r[`RTC_S_B75] && (stat_r[`RTC_S_B85] || !$past(b85)))
      else $error("battery warning not recorded");
   a_brownout: assert property (
      trip_r == 3'h2 && vdd_s[2] |=> stat_r[`RTC_S_LVDD])
      else $error("brownout not recorded");
   a_evt_pin: assert property (
      $rose(event_detect_out_oe_o) |-> $past(ev_hit) ##1 event_detect_out_oe_o
         || $past(wr_st))
      else $error("event pin not held");
   a_bus_gate: assert property (
      req && !wb_ack_o && !bus_ok |=> wb_ack_o && wb_dat_o == 32'h0)
      else $error("gated bus returned data");
   a_ack_pulse: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// ===== pkg/rtc_defines.svh
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
// Register pages, wb_adr_i[11:5] (RAM on wb_adr_i[11:9]), and slots within a page, wb_adr_i[4:2]
`define RTC_PG_CAL    7'h00
`define RTC_PG_CTL    7'h01
`define RTC_PG_ALM0   7'h02
`define RTC_PG_EVT    7'h04
`define RTC_PG_RAM    3'h1
`define RTC_I_CTRL    3'h0
`define RTC_I_STAT    3'h1
`define RTC_I_TRIP    3'h2
`define RTC_I_EVIDX   3'h3
`define RTC_I_NONE    3'h7
// Calendar field order
`define RTC_F_SEC     0
`define RTC_F_MIN     1
`define RTC_F_HOUR    2
`define RTC_F_DATE    3
`define RTC_F_MON     4
`define RTC_F_YEAR    5
`define RTC_F_WDAY    6
`define RTC_NFIELD    7
// Control bits
`define RTC_C_60HZ    0
`define RTC_C_BUSBAT  1
`define RTC_C_EVEN    2
`define RTC_C_DST     3
`define RTC_C_IRQEN   4
`define RTC_C_RPT     6
// Status bits, then alarm enable and event clear bits
`define RTC_S_ALM     0
`define RTC_S_EVT     2
`define RTC_S_LVDD    3
`define RTC_S_B85     4
`define RTC_S_B75     5
`define RTC_A_EN      7
`define RTC_EV_CLR    7
// Calendar limits, reset values and DST hour
`define RTC_MAX_SEC   8'h3b
`define RTC_MAX_HOUR  8'h17
`define RTC_MAX_MON   8'h0c
`define RTC_MAX_YEAR  8'h63
`define RTC_MAX_WDAY  8'h06
`define RTC_RST_DAY   8'h01
`define RTC_DST_HOUR  8'h02
// Timebase counts, in edges of the selected source; mains loss in crystal edges; then sizes
`define RTC_XTAL_HZ   32768
`define RTC_MAINS50   50
`define RTC_MAINS60   60
`define RTC_MAINS_LOSS 2048
`define RTC_BO_LEVELS 6
`define RTC_RAM_WORDS 128
`define RTC_EVT_SLOTS 4
`endif

// ===== pkg/rtc_pkg.sv
package rtc_pkg;
   typedef logic [6:0][7:0] rtc_stamp_t;
   typedef enum logic {RTC_SRC_MAINS, RTC_SRC_XTAL} rtc_src_e;
endpackage

// ===== verification/rtc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// Crystal runs free; mains square wave only while enabled
module rtc_src_model (
   input  wire logic mains_en_i,
   output logic      xtal_o,
   output logic      mains_o
);
   int cnt;
   initial begin
      xtal_o  = 1'b0;
      mains_o = 1'b0;
      cnt     = 0;
   end
   always #24 xtal_o = ~xtal_o;
   // Mains held low when lost, so no stray edge reaches the timebase
   always @(posedge xtal_o) begin
      cnt = (cnt + 1) % 2;
      if (!mains_en_i) begin
         mains_o <= 1'b0;
      end else if (cnt == 0) begin
         mains_o <= ~mains_o;
      end
   end
endmodule
`default_nettype wire

// ===== verification/tb_rtc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_top;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
   logic [11:0] adr = 0;
   logic [31:0] dat = 0, dout;
   logic        bat = 0, b85 = 0, b75 = 0, ev = 0, men = 1, xt, mn;
   logic [5:0]  vdd = 0;
   logic        irq_oe, evd_oe;
   logic [7:0]  rv;
   int          mismatches = 0, tests_run = 0;
   always #2.5 clk_i = ~clk_i;
   rtc_src_model src (.mains_en_i(men), .xtal_o(xt), .mains_o(mn));
   // Short second keeps the run small
   rtc_top #(.XTAL_HZ(8), .MAINS_LOSS(4)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
      .mains_i(mn), .xtal_i(xt), .on_battery_i(bat), .bat_below85_i(b85),
      .bat_below75_i(b75), .vdd_below_i(vdd), .event_input_i(ev),
      .irq_n_o(), .irq_oe_o(irq_oe), .event_detect_out_n_o(),
      .event_detect_out_oe_o(evd_oe));
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 100);
      rv = dout[7:0];
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic chk(input logic [11:0] a, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH reg %h expected %h seen %h", a, e, g);
      end
   endtask
   task automatic chkb(input string s, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", s, e, g);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(a, e, rv);
   endtask
   // Bounded poll until masked bits show up
   task automatic poll(input logic [11:0] a, input logic [7:0] m);
      int n;
      n = 0;
      do begin
         xfer(1'b0, a, 8'h00);
         n++;
      end while ((rv & m) !== m && n < 5000);
      chk(a, m, rv & m);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      // About 80000 clocks, several times the expected run
      #400000;
      mismatches++;
      end_sim();
   end
   initial begin
      logic [7:0] rst_v [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
      logic [7:0] set_v [7] = '{8'h3b, 8'h3b, 8'h17, 8'h1c, 8'h02, 8'h00, 8'h06};
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int j = 0; j < 7; j++) rdc(12'(4 * j), rst_v[j]);
      rdc(12'h020, 8'h00);
      wr(12'h100, 8'h5a);
      rdc(12'h100, 8'h00);
      done("reset");
      wr(12'h200, 8'ha5);
      wr(12'h3fc, 8'h3c);
      rdc(12'h200, 8'ha5);
      rdc(12'h3fc, 8'h3c);
      done("memory");
      // Leap year 2000 then plain 2001, Feb 28 23:59:59
      for (int y = 0; y < 2; y++) begin
         set_v[5] = 8'(y);
         for (int j = 0; j < 7; j++) wr(12'(4 * j), set_v[j]);
         poll(12'h018, 8'h06);
         xfer(1'b0, 12'h008, 8'h00);
         while (rv !== 8'h00 && tests_run < 9000) xfer(1'b0, 12'h008, 8'h00);
         rdc(12'h00c, y == 0 ? 8'h1d : 8'h01);
         rdc(12'h010, y == 0 ? 8'h02 : 8'h03);
         rdc(12'h018, 8'h00);
      end
      done("calendar");
      wr(12'h020, 8'h02);
      bat <= 1'b1;
      men <= 1'b0;
      poll(12'h024, 8'hc0);
      rdc(12'h200, 8'ha5);
      wr(12'h020, 8'h00);
      rdc(12'h200, 8'h00);
      bat <= 1'b0;
      repeat (8) @(posedge clk_i);
      rdc(12'h200, 8'ha5);
      done("backup");
      bat <= 1'b1;
      wr(12'h020, 8'h00);
      rdc(12'h020, 8'h00);
      bat <= 1'b0;
      repeat (8) @(posedge clk_i);
      wr(12'h020, 8'h52);
      bat <= 1'b1;
      wr(12'h040, 8'h85);
      poll(12'h024, 8'h01);
      chkb("irq", 1'b1, irq_oe);
      wr(12'h024, 8'h01);
      repeat (2) @(posedge clk_i);
      chkb("irq", 1'b0, irq_oe);
      poll(12'h024, 8'h01);
      rdc(12'h000, 8'h05);
      wr(12'h024, 8'h01);
      done("alarm");
      wr(12'h020, 8'h06);
      ev <= 1'b1;
      poll(12'h024, 8'h04);
      chkb("event_detect_out", 1'b1, evd_oe);
      xfer(1'b0, 12'h00c, 8'h00);
      rdc(12'h08c, rv);
      ev <= 1'b0;
      wr(12'h024, 8'h04);
      repeat (2) @(posedge clk_i);
      chkb("event_detect_out", 1'b0, evd_oe);
      done("event");
      b85 <= 1'b1;
      poll(12'h024, 8'h10);
      b75 <= 1'b1;
      poll(12'h024, 8'h30);
      wr(12'h028, 8'h02);
      vdd <= 6'h04;
      poll(12'h024, 8'h08);
      done("supply");
      end_sim();
   end
endmodule
`default_nettype wire
